// [lpm_pkg.sv]
/*
 * Package for the legacy activity monitor: configuration offsets, field
 * positions, reset values, timing constants and the system state type.
 * Assumes a byte-wide configuration port addressed by configuration offset.
 */
package lpm_pkg;
	localparam logic [7:0] OFF_STANDBY_CFG  = 8'h54;
	localparam logic [7:0] OFF_APM_CFG      = 8'h55;
	localparam logic [7:0] OFF_DISPLAY_CFG  = 8'h59;
	localparam logic [7:0] OFF_STANDBY_SEL  = 8'h60;
	localparam logic [7:0] OFF_DISPLAY_SEL  = 8'h64;
	localparam logic [7:0] OFF_FLOPPY_PAR   = 8'h68;
	localparam logic [7:0] OFF_DEV_ENABLES  = 8'h6c;
	localparam logic [7:0] OFF_SER_PAR_EN   = 8'h70;
	localparam logic [7:0] OFF_INPUT_PIN    = 8'h72;
	localparam logic [7:0] OFF_RESET_CAUSE  = 8'h74;
	localparam logic [7:0] OFF_BUS_ACTIVITY_EVENT      = 8'h75;
	localparam logic [7:0] OFF_SYS_STATE    = 8'h82;
	localparam logic [7:0] OFF_MEM_GROUP_A  = 8'h94;
	localparam logic [7:0] OFF_IO_GROUP_C   = 8'ha4;
	localparam logic [7:0] OFF_RING_COUNT   = 8'hb7;
	localparam logic [7:0] OFF_IDLE_MASK    = 8'hc8;
	localparam logic [7:0] BYTE_RESET       = 8'h00;
	localparam logic [15:0] HALF_RESET      = 16'h0000;
	localparam logic [31:0] WORD_RESET      = 32'h0000_0000;
	// Device enable bit positions
	localparam int EN_PRI_DRQ   = 0;
	localparam int EN_SEC_DRQ   = 1;
	localparam int EN_VID_MEM   = 22;
	localparam int EN_VID_CS    = 23;
	localparam int EN_VID_IO    = 24;
	localparam int EN_FDD_DMA_REQUEST_TWO  = 26;
	localparam int EN_KBD_IRQ1  = 27;
	localparam int EN_KBD_IRQ12 = 28;
	localparam int EN_PRI_ALT   = 29;
	localparam int EN_SEC_ALT   = 30;
	localparam int EN_INT_IDE   = 31;
	// Serial and parallel enable bit positions, and the bus activity enable bit
	localparam int SP_PAR_BASE  = 8;
	localparam int SP_PAR_EVENT = 11;
	localparam int SP_IOGP_EN   = 12;
	localparam int SP_EC_PORTS  = 13;
	localparam int BA_ENABLE    = 14;
	// Event vector positions
	localparam int EV_PRI = 0;
	localparam int EV_SEC = 1;
	localparam int EV_VID = 2;
	localparam int EV_FDD = 3;
	localparam int EV_SER = 4;
	localparam int EV_KBD = 5;
	localparam int EV_PAR = 6;
	localparam int EV_MEM = 7;
	localparam int EV_IOG = 8;
	localparam int EV_USB = 9;
	localparam int EV_BUS = 10;
	localparam int EV_RING = 11;
	localparam int EV_W   = 16;
	// Timer tick: one idle-timer unit
	localparam int CLK_MHZ      = 250;
	localparam int TICK_US      = 1000;
	localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
	typedef enum logic [1:0] {
		LPM_ON      = 2'b01,
		LPM_STANDBY = 2'b10
	} lpm_sys_e;
endpackage

// [lpm_monitor.sv]
/*
 * Legacy activity monitor: event decode, standby, display and APM idle
 * timers, system state, bus activity and ring counting.
 * Assumes observed bus cycles arrive as one-cycle pulses on core_clk and
 * that pin inputs are asynchronous.
 */
`timescale 1ns/100ps

module lpm_monitor
	import lpm_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [7:0]  cfg_wdata,
	output logic      [7:0]  cfg_rdata,
	input  wire logic        cyc_valid,
	input  wire logic        cyc_io,
	input  wire logic [31:0] cyc_addr,
	input  wire logic        ide_pri_access,
	input  wire logic        ide_sec_access,
	input  wire logic        ide_pri_dma_req,
	input  wire logic        ide_sec_dma_req,
	input  wire logic        usb_attach_change,
	input  wire logic        usb_busy,
	input  wire logic [7:0]  dma_req,
	input  wire logic        irq_keyboard,
	input  wire logic        irq_mouse,
	input  wire logic        video_chip_select_n,
	input  wire logic        ring_indicate,
	input  wire logic        pci_target_ready_sample,
	output logic             system_standby,
	output logic             standby_timeout_smi,
	output logic             standby_to_on_smi,
	output logic             display_timeout_smi,
	output logic             display_activity_smi,
	output logic             apm_timeout_smi,
	output logic             bus_activity_event
);
	function automatic logic io_in(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		io_in = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [15:0] com_base(input int i);
		case (i)
			0: com_base = 16'h03f8;
			1: com_base = 16'h02f8;
			2: com_base = 16'h03e8;
			3: com_base = 16'h02e8;
			4: com_base = 16'h0338;
			5: com_base = 16'h0238;
			6: com_base = 16'h02e0;
			default: com_base = 16'h0220;
		endcase
	endfunction

	logic [7:0]  standby_cfg_r, apm_cfg_r, display_cfg_r, floppy_par_r, reset_cause_r, ring_match_r, idle_mask_r;
	logic [15:0] standby_sel_r, display_sel_r, ser_par_r, input_pin_r, bus_activity_event_r, io_group_c_r;
	logic [31:0] dev_en_r, mem_group_a_r;
	lpm_sys_e    state_r;
	logic [12:0] sync1_r, sync2_r;
	logic        ring_prev_r;

	// Register writes
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			standby_cfg_r <= BYTE_RESET;
			apm_cfg_r     <= BYTE_RESET;
			display_cfg_r <= BYTE_RESET;
			floppy_par_r  <= BYTE_RESET;
			ring_match_r  <= BYTE_RESET;
			idle_mask_r   <= BYTE_RESET;
			standby_sel_r <= HALF_RESET;
			display_sel_r <= HALF_RESET;
			ser_par_r     <= HALF_RESET;
			input_pin_r   <= HALF_RESET;
			bus_activity_event_r     <= HALF_RESET;
			io_group_c_r  <= HALF_RESET;
			dev_en_r      <= WORD_RESET;
			mem_group_a_r <= WORD_RESET;
		end
		else if (cfg_wr)
		begin
			case (cfg_addr)
				OFF_STANDBY_CFG: standby_cfg_r <= cfg_wdata;
				OFF_APM_CFG: apm_cfg_r <= cfg_wdata;
				OFF_DISPLAY_CFG: display_cfg_r <= cfg_wdata;
				OFF_FLOPPY_PAR: floppy_par_r <= cfg_wdata;
				OFF_RING_COUNT: ring_match_r <= cfg_wdata;
				OFF_IDLE_MASK: idle_mask_r <= cfg_wdata;
				OFF_STANDBY_SEL, OFF_STANDBY_SEL + 8'h01: standby_sel_r[8*cfg_addr[0] +: 8] <= cfg_wdata;
				OFF_DISPLAY_SEL, OFF_DISPLAY_SEL + 8'h01: display_sel_r[8*cfg_addr[0] +: 8] <= cfg_wdata;
				OFF_SER_PAR_EN, OFF_SER_PAR_EN + 8'h01: ser_par_r[8*cfg_addr[0] +: 8] <= cfg_wdata;
				OFF_INPUT_PIN, OFF_INPUT_PIN + 8'h01: input_pin_r[8*cfg_addr[0] +: 8] <= cfg_wdata;
				OFF_BUS_ACTIVITY_EVENT: bus_activity_event_r[7:0] <= cfg_wdata;
				OFF_BUS_ACTIVITY_EVENT + 8'h01: bus_activity_event_r[15:8] <= cfg_wdata;
				OFF_IO_GROUP_C, OFF_IO_GROUP_C + 8'h01: io_group_c_r[8*cfg_addr[0] +: 8] <= cfg_wdata;
				OFF_DEV_ENABLES, OFF_DEV_ENABLES + 8'h01, OFF_DEV_ENABLES + 8'h02, OFF_DEV_ENABLES + 8'h03:
					dev_en_r[8*cfg_addr[1:0] +: 8] <= cfg_wdata;
				OFF_MEM_GROUP_A, OFF_MEM_GROUP_A + 8'h01, OFF_MEM_GROUP_A + 8'h02, OFF_MEM_GROUP_A + 8'h03:
					mem_group_a_r[8*cfg_addr[1:0] +: 8] <= cfg_wdata;
				default: ;
			endcase
		end
	end

	// Pin synchronisers
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			sync1_r     <= 13'h1800;
			sync2_r     <= 13'h1800;
			ring_prev_r <= 1'b0;
		end
		else
		begin
			sync1_r     <= {pci_target_ready_sample, video_chip_select_n, ring_indicate, irq_mouse, irq_keyboard, dma_req};
			sync2_r     <= sync1_r;
			ring_prev_r <= sync2_r[10];
		end
	end

	logic [7:0]  drq_s;
	logic        ring_rise, trdy_s, vcs_s;
	logic [15:0] ioa;
	logic        io_cyc, mem_cyc;
	assign drq_s     = sync2_r[7:0];
	assign ring_rise = sync2_r[10] && !ring_prev_r;
	assign vcs_s     = !sync2_r[11];
	assign trdy_s    = !sync2_r[12];
	assign ioa       = cyc_addr[15:0];
	assign io_cyc    = cyc_valid && cyc_io;
	assign mem_cyc   = cyc_valid && !cyc_io;

	// Event decode
	logic [EV_W-1:0] ev_raw, ev;
	logic            ring_event_r, bus_activity_event_pulse;
	logic [15:0]     fdd_lo;
	logic            ser_hit, par_hit, par_drq;
	always_comb
	begin
		fdd_lo  = floppy_par_r[0] ? 16'h0370 : 16'h03f0;
		ser_hit = 1'b0;
		for (int i = 0; i < 8; i++)
			if (ser_par_r[i] && io_in(ioa, com_base(i), com_base(i) + 16'h0007))
				ser_hit = 1'b1;
		par_hit = (ser_par_r[SP_PAR_BASE] && io_in(ioa, 16'h0378, 16'h037f))
			|| (ser_par_r[SP_PAR_BASE + 1] && io_in(ioa, 16'h0278, 16'h027f))
			|| (ser_par_r[SP_PAR_BASE + 2] && io_in(ioa, 16'h03bc, 16'h03bf));
		case (floppy_par_r[2:1])
			2'b01: par_drq = drq_s[0];
			2'b10: par_drq = drq_s[1];
			2'b11: par_drq = drq_s[3];
			default: par_drq = 1'b0;
		endcase
		ev_raw = '0;
		ev_raw[EV_PRI] = (io_cyc && (io_in(ioa, 16'h01f0, 16'h01f7) || (dev_en_r[EN_PRI_ALT] && ioa == 16'h03f6)))
			|| (dev_en_r[EN_INT_IDE] && ide_pri_access) || (dev_en_r[EN_PRI_DRQ] && ide_pri_dma_req);
		ev_raw[EV_SEC] = (io_cyc && (io_in(ioa, 16'h0170, 16'h0177) || (dev_en_r[EN_SEC_ALT] && ioa == 16'h0376)))
			|| (dev_en_r[EN_INT_IDE] && ide_sec_access) || (dev_en_r[EN_SEC_DRQ] && ide_sec_dma_req);
		ev_raw[EV_VID] = (dev_en_r[EN_VID_MEM] && mem_cyc && cyc_addr >= 32'h000a_0000 && cyc_addr <= 32'h000b_ffff)
			|| (dev_en_r[EN_VID_CS] && vcs_s)
			|| (dev_en_r[EN_VID_IO] && io_cyc && io_in(ioa, 16'h03b0, 16'h03df));
		ev_raw[EV_FDD] = (io_cyc && io_in(ioa, fdd_lo, fdd_lo + 16'h0007))
			|| (dev_en_r[EN_FDD_DMA_REQUEST_TWO] && drq_s[2]);
		ev_raw[EV_SER] = io_cyc && ser_hit;
		ev_raw[EV_KBD] = (io_cyc && (ioa == 16'h0060 || ioa == 16'h0064))
			|| (dev_en_r[EN_KBD_IRQ1] && sync2_r[8]) || (dev_en_r[EN_KBD_IRQ12] && sync2_r[9]);
		ev_raw[EV_PAR] = ser_par_r[SP_PAR_EVENT] && ((io_cyc && par_hit) || par_drq);
		ev_raw[EV_MEM] = mem_group_a_r[0] && mem_cyc
			&& (((cyc_addr[31:14] ^ mem_group_a_r[31:14]) & ~{8'h00, mem_group_a_r[13:4]}) == 18'h0);
		ev_raw[EV_IOG] = io_cyc && ((ser_par_r[SP_IOGP_EN]
			&& (((ioa[15:2] ^ io_group_c_r[15:2]) & ~{12'h000, io_group_c_r[1:0]}) == 14'h0))
			|| (ser_par_r[SP_EC_PORTS] && (ioa == 16'h0062 || ioa == 16'h0066)));
		ev_raw[EV_USB] = usb_attach_change || usb_busy;
		ev_raw[EV_BUS] = bus_activity_event_pulse;
		ev_raw[EV_RING] = ring_event_r;
		ev = (idle_mask_r != BYTE_RESET) ? '0 : ev_raw;
	end

	logic sb_event, disp_event;
	assign sb_event   = |(ev & standby_sel_r);
	assign disp_event = |(ev & display_sel_r);

	// Timer tick divider
	logic [31:0] tick_cnt_r;
	logic        tick;
	assign tick = (tick_cnt_r == 32'(TICK_LEN - 1));
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			tick_cnt_r <= WORD_RESET;
		else
			tick_cnt_r <= tick ? WORD_RESET : tick_cnt_r + 32'h1;
	end

	// Standby timer and system state
	logic [7:0] sb_cnt_r;
	logic       sb_run_r, sb_expire, wr_sb, wr_state;
	assign wr_sb     = cfg_wr && cfg_addr == OFF_STANDBY_CFG;
	assign wr_state  = cfg_wr && cfg_addr == OFF_SYS_STATE;
	assign sb_expire = sb_run_r && tick && sb_cnt_r == 8'h01 && !sb_event && !wr_sb;
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			sb_cnt_r <= BYTE_RESET;
			sb_run_r <= 1'b0;
		end
		else if (wr_sb)
		begin
			sb_cnt_r <= cfg_wdata;
			sb_run_r <= cfg_wdata != BYTE_RESET;
		end
		else if (sb_event && standby_cfg_r != BYTE_RESET)
		begin
			sb_cnt_r <= standby_cfg_r;
			sb_run_r <= 1'b1;
		end
		else if (sb_run_r && tick)
		begin
			sb_cnt_r <= sb_cnt_r - 8'h01;
			sb_run_r <= sb_cnt_r != 8'h01;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state_r             <= LPM_ON;
			standby_timeout_smi <= 1'b0;
			standby_to_on_smi   <= 1'b0;
			reset_cause_r       <= BYTE_RESET;
		end
		else
		begin
			standby_timeout_smi <= sb_expire;
			standby_to_on_smi   <= !wr_state && sb_event && state_r == LPM_STANDBY;
			if (!wr_state && sb_event && state_r == LPM_STANDBY)
				reset_cause_r <= ev[7:0];
			if (wr_state)
				state_r <= cfg_wdata[0] ? LPM_STANDBY : LPM_ON;
			else if (sb_event && state_r == LPM_STANDBY)
				state_r <= LPM_ON;
			else if (sb_expire)
				state_r <= LPM_STANDBY;
		end
	end
	assign system_standby = state_r[1];

	// Display timer
	logic [7:0] dp_cnt_r;
	logic       dp_run_r, dp_expired_r, dp_expire, wr_dp;
	assign wr_dp     = cfg_wr && cfg_addr == OFF_DISPLAY_CFG;
	assign dp_expire = dp_run_r && tick && dp_cnt_r == 8'h01 && !disp_event && !wr_dp;
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			dp_cnt_r             <= BYTE_RESET;
			dp_run_r             <= 1'b0;
			dp_expired_r         <= 1'b0;
			display_timeout_smi  <= 1'b0;
			display_activity_smi <= 1'b0;
		end
		else
		begin
			display_timeout_smi  <= dp_expire;
			display_activity_smi <= disp_event && dp_expired_r;
			if (dp_expire)
				dp_expired_r <= 1'b1;
			else if (disp_event)
				dp_expired_r <= 1'b0;
			if (wr_dp)
			begin
				dp_cnt_r <= cfg_wdata;
				dp_run_r <= cfg_wdata != BYTE_RESET;
			end
			else if (disp_event && display_cfg_r != BYTE_RESET)
			begin
				dp_cnt_r <= display_cfg_r;
				dp_run_r <= 1'b1;
			end
			else if (dp_run_r && tick)
			begin
				dp_cnt_r <= dp_cnt_r - 8'h01;
				dp_run_r <= dp_cnt_r != 8'h01;
			end
		end
	end

	// APM timer
	logic [5:0] apm_cnt_r;
	logic       apm_run_r, apm_expire, wr_apm;
	assign wr_apm     = cfg_wr && cfg_addr == OFF_APM_CFG;
	assign apm_expire = apm_run_r && tick && apm_cnt_r == 6'h01 && !wr_apm;
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			apm_cnt_r       <= 6'h00;
			apm_run_r       <= 1'b0;
			apm_timeout_smi <= 1'b0;
		end
		else
		begin
			apm_timeout_smi <= apm_expire;
			if (wr_apm)
			begin
				apm_cnt_r <= cfg_wdata[5:0];
				apm_run_r <= cfg_wdata[5:0] != 6'h00;
			end
			else if (apm_expire)
			begin
				apm_cnt_r <= apm_cfg_r[6] ? apm_cfg_r[5:0] : 6'h00;
				apm_run_r <= apm_cfg_r[6];
			end
			else if (apm_run_r && tick)
				apm_cnt_r <= apm_cnt_r - 6'h01;
		end
	end

	// Bus activity window
	logic [7:0] win_cnt_r, trdy_cnt_r;
	logic [8:0] trdy_sum;
	logic       win_end;
	assign trdy_sum      = {1'b0, trdy_cnt_r} + {8'h00, trdy_s};
	assign win_end       = bus_activity_event_r[BA_ENABLE] && win_cnt_r == bus_activity_event_r[7:0] - 8'h01;
	assign bus_activity_event_pulse = bus_activity_event;
	always_ff @(posedge core_clk)
	begin
		if (!reset_n || !bus_activity_event_r[BA_ENABLE])
		begin
			win_cnt_r          <= BYTE_RESET;
			trdy_cnt_r         <= BYTE_RESET;
			bus_activity_event <= 1'b0;
		end
		else
		begin
			bus_activity_event <= win_end && trdy_sum > {3'b000, bus_activity_event_r[13:8]};
			win_cnt_r          <= win_end ? BYTE_RESET : win_cnt_r + 8'h01;
			trdy_cnt_r         <= win_end ? BYTE_RESET : (trdy_sum[8] ? 8'hff : trdy_sum[7:0]);
		end
	end

	// Ring counter
	logic [7:0] ring_cnt_r;
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			ring_cnt_r   <= BYTE_RESET;
			ring_event_r <= 1'b0;
		end
		else
		begin
			ring_event_r <= ring_rise && (ring_cnt_r + 8'h01 >= ring_match_r);
			if (ring_rise)
				ring_cnt_r <= (ring_cnt_r + 8'h01 >= ring_match_r) ? BYTE_RESET : ring_cnt_r + 8'h01;
		end
	end

	// Register reads
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			cfg_rdata <= BYTE_RESET;
		else if (cfg_rd)
		begin
			case (cfg_addr)
				OFF_STANDBY_CFG: cfg_rdata <= standby_cfg_r;
				OFF_APM_CFG: cfg_rdata <= apm_cfg_r;
				OFF_DISPLAY_CFG: cfg_rdata <= display_cfg_r;
				OFF_FLOPPY_PAR: cfg_rdata <= floppy_par_r;
				OFF_RESET_CAUSE: cfg_rdata <= reset_cause_r;
				OFF_SYS_STATE: cfg_rdata <= {7'h00, state_r == LPM_STANDBY};
				OFF_RING_COUNT: cfg_rdata <= ring_match_r;
				OFF_IDLE_MASK: cfg_rdata <= idle_mask_r;
				OFF_STANDBY_SEL, OFF_STANDBY_SEL + 8'h01: cfg_rdata <= standby_sel_r[8*cfg_addr[0] +: 8];
				OFF_DISPLAY_SEL, OFF_DISPLAY_SEL + 8'h01: cfg_rdata <= display_sel_r[8*cfg_addr[0] +: 8];
				OFF_SER_PAR_EN, OFF_SER_PAR_EN + 8'h01: cfg_rdata <= ser_par_r[8*cfg_addr[0] +: 8];
				OFF_INPUT_PIN, OFF_INPUT_PIN + 8'h01: cfg_rdata <= input_pin_r[8*cfg_addr[0] +: 8];
				OFF_BUS_ACTIVITY_EVENT: cfg_rdata <= bus_activity_event_r[7:0];
				OFF_BUS_ACTIVITY_EVENT + 8'h01: cfg_rdata <= bus_activity_event_r[15:8];
				OFF_IO_GROUP_C, OFF_IO_GROUP_C + 8'h01: cfg_rdata <= io_group_c_r[8*cfg_addr[0] +: 8];
				OFF_DEV_ENABLES, OFF_DEV_ENABLES + 8'h01, OFF_DEV_ENABLES + 8'h02, OFF_DEV_ENABLES + 8'h03:
					cfg_rdata <= dev_en_r[8*cfg_addr[1:0] +: 8];
				OFF_MEM_GROUP_A, OFF_MEM_GROUP_A + 8'h01, OFF_MEM_GROUP_A + 8'h02, OFF_MEM_GROUP_A + 8'h03:
					cfg_rdata <= mem_group_a_r[8*cfg_addr[1:0] +: 8];
				default: cfg_rdata <= BYTE_RESET;
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_sb_timeout;
		sb_expire ##1 (system_standby && standby_timeout_smi);
	endsequence
	sequence s_wake;
		standby_to_on_smi && !system_standby;
	endsequence

	chk_standby_start: assert property (wr_sb && cfg_wdata != 8'h00 |=> sb_run_r && sb_cnt_r == $past(cfg_wdata))
		else $error("standby timer did not start on write");
	chk_standby_reload: assert property (sb_event && !wr_sb && standby_cfg_r != 8'h00 |=> sb_cnt_r == $past(standby_cfg_r))
		else $error("standby timer not reloaded by event");
	chk_standby_timeout: assert property (sb_expire && !wr_state |-> s_sb_timeout ##0 !sb_run_r)
		else $error("standby expiry did not enter standby");
	chk_standby_wake: assert property (system_standby && sb_event && !wr_state |=> s_wake)
		else $error("event in standby did not wake");
	chk_state_readback: assert property (cfg_rd && cfg_addr == 8'h82 |=> cfg_rdata[0] == $past(system_standby))
		else $error("state byte readback wrong");
	chk_display_smi: assert property (dp_expire |=> display_timeout_smi && dp_expired_r)
		else $error("display timeout not flagged");
	chk_apm_oneshot: assert property (apm_expire && !apm_cfg_r[6] |=> apm_timeout_smi && !apm_run_r)
		else $error("apm one-shot did not stop");
	chk_apm_periodic: assert property (apm_expire && apm_cfg_r[6] |=> apm_run_r && apm_timeout_smi)
		else $error("apm periodic did not reload");
	chk_idle_mask: assert property (idle_mask_r != 8'h00 |-> !sb_event && !disp_event)
		else $error("masked event reached a timer");
	chk_bus_window: assert property (bus_activity_event |-> $past(win_end) && $past(trdy_sum) > {3'b000, $past(bus_activity_event_r[13:8])})
		else $error("bus activity raised without threshold");
endmodule // lpm_monitor

// [lpm_bus_model.sv]
/*
 * Host bus model: issues observed I/O or memory cycles as one-cycle pulses.
 * Assumes the monitor samples them on the rising edge of core_clk.
 */
`timescale 1ns/100ps
module lpm_bus_model
	import lpm_pkg::*;
(
	input  wire logic        core_clk,
	output logic             cyc_valid,
	output logic             cyc_io,
	output logic [31:0]      cyc_addr
);
	initial
	begin
		cyc_valid = 1'b0;
		cyc_io    = 1'b0;
		cyc_addr  = 32'hffff_ffff;
	end
	// Optional idle gap, one cycle, then released address scrambled
	task automatic bus_cycle(input int gap, input logic io, input logic [31:0] addr);
		repeat (gap) @(negedge core_clk);
		@(negedge core_clk);
		cyc_valid = 1'b1;
		cyc_io    = io;
		cyc_addr  = addr;
		@(negedge core_clk);
		cyc_valid = 1'b0;
		cyc_io    = ~io;
		cyc_addr  = ~addr;
	endtask
endmodule // lpm_bus_model

// [lpm_monitor_tb.sv]
/*
 * Testbench for the activity monitor: timers, state, masking, decode, bus load.
 * Assumes TICK_LEN of 4 and pulse outputs lasting one cycle.
 */
`timescale 1ns/100ps
module lpm_monitor_tb
	import lpm_pkg::*;
;
	logic        core_clk, reset_n, cfg_wr, cfg_rd, trdy_n;
	logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
	logic        cyc_valid, cyc_io;
	logic [31:0] cyc_addr;
	logic        sb, sb_to, sb_on, d_to, d_act, apm, bact;
	logic        ide_pri, usb_att, usb_bsy, kbd, mouse, vcs_n, ring;
	logic [7:0]  drq;
	logic [7:0]  cnt [6];
	logic [7:0]  snap [6];
	int          errors, tests_run;

	lpm_bus_model bus (.core_clk(core_clk), .cyc_valid(cyc_valid), .cyc_io(cyc_io), .cyc_addr(cyc_addr));
	lpm_monitor #(.TICK_LEN(4)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cyc_valid(cyc_valid), .cyc_io(cyc_io), .cyc_addr(cyc_addr),
		.ide_pri_access(ide_pri), .ide_sec_access(1'b0), .ide_pri_dma_req(1'b0),
		.ide_sec_dma_req(1'b0), .usb_attach_change(usb_att), .usb_busy(usb_bsy),
		.dma_req(drq), .irq_keyboard(kbd), .irq_mouse(mouse),
		.video_chip_select_n(vcs_n), .ring_indicate(ring),
		.pci_target_ready_sample(trdy_n), .system_standby(sb),
		.standby_timeout_smi(sb_to), .standby_to_on_smi(sb_on),
		.display_timeout_smi(d_to), .display_activity_smi(d_act),
		.apm_timeout_smi(apm), .bus_activity_event(bact));

	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Pulse counters
	always @(posedge core_clk)
	begin
		if (reset_n !== 1'b1)
			cnt <= '{default: 8'h00};
		else
		begin
			cnt[0] <= cnt[0] + {7'h00, sb_to === 1'b1};
			cnt[1] <= cnt[1] + {7'h00, sb_on === 1'b1};
			cnt[2] <= cnt[2] + {7'h00, d_to === 1'b1};
			cnt[3] <= cnt[3] + {7'h00, d_act === 1'b1};
			cnt[4] <= cnt[4] + {7'h00, apm === 1'b1};
			cnt[5] <= cnt[5] + {7'h00, bact === 1'b1};
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge core_clk);
		cfg_wr = 1'b0;
		cfg_wdata = ~d;
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge core_clk);
		cfg_rd = 1'b0;
		cyc(1);
		chk(what, exp, cfg_rdata);
	endtask
	task automatic mark();
		snap = cnt;
	endtask
	// Judge one wake attempt, then force standby again
	task automatic wake_chk(input string what, input logic [7:0] exp);
		cyc(6);
		chk(what, exp, dl(1));
		wr(OFF_SYS_STATE, 8'h01);
		mark();
	endtask
	function automatic logic [7:0] dl(input int i);
		return cnt[i] - snap[i];
	endfunction

	task automatic t_reset();
		rd_chk("standby cfg", OFF_STANDBY_CFG, 8'h00);
		rd_chk("state", OFF_SYS_STATE, 8'h00);
		wr(8'h40, 8'h5a);
		rd_chk("unmapped", 8'h40, 8'h00);
	endtask
	task automatic t_standby();
		wr(OFF_STANDBY_SEL, 8'h01);
		mark();
		wr(OFF_STANDBY_CFG, 8'h03);
		for (int i = 0; i < 5; i++)
			bus.bus_cycle(4, 1'b1, 32'h0000_01f0 + i);
		chk("no expiry", 8'h00, dl(0));
		cyc(16);
		chk("timeout smi", 8'h01, dl(0));
		chk("standby", 8'h01, {7'h00, sb});
		rd_chk("state rd", OFF_SYS_STATE, 8'h01);
		cyc(16);
		chk("halted", 8'h01, dl(0));
		bus.bus_cycle(0, 1'b1, 32'h0000_01f7);
		cyc(2);
		chk("wake smi", 8'h01, dl(1));
		chk("on", 8'h00, {7'h00, sb});
	endtask
	task automatic t_mask();
		wr(OFF_STANDBY_CFG, 8'h00);
		wr(OFF_IDLE_MASK, 8'h01);
		wr(OFF_SYS_STATE, 8'h01);
		chk("forced", 8'h01, {7'h00, sb});
		mark();
		bus.bus_cycle(0, 1'b1, 32'h0000_01f0);
		cyc(4);
		chk("masked", 8'h00, dl(1));
		wr(OFF_IDLE_MASK, 8'h00);
		bus.bus_cycle(2, 1'b1, 32'h0000_03f6);
		cyc(4);
		chk("alt off", 8'h00, dl(1));
		wr(OFF_DEV_ENABLES + 8'h03, 8'h20);
		bus.bus_cycle(0, 1'b1, 32'h0000_03f6);
		cyc(2);
		chk("alt on", 8'h01, dl(1));
		chk("on", 8'h00, {7'h00, sb});
	endtask
	task automatic t_display();
		wr(OFF_DISPLAY_SEL, 8'h20);
		mark();
		wr(OFF_DISPLAY_CFG, 8'h01);
		cyc(12);
		chk("disp to", 8'h01, dl(2));
		bus.bus_cycle(0, 1'b1, 32'h0000_0064);
		cyc(2);
		chk("disp act", 8'h01, dl(3));
		wr(OFF_DISPLAY_CFG, 8'h00);
	endtask
	task automatic t_apm();
		mark();
		wr(OFF_APM_CFG, 8'h02);
		cyc(40);
		chk("apm once", 8'h01, dl(4));
		mark();
		wr(OFF_APM_CFG, 8'h42);
		cyc(40);
		chk("apm again", 8'h01, {7'h00, dl(4) >= 8'h04});
		wr(OFF_APM_CFG, 8'h00);
	endtask
	task automatic t_busact();
		wr(OFF_BUS_ACTIVITY_EVENT, 8'h08);
		wr(OFF_BUS_ACTIVITY_EVENT + 8'h01, 8'h42);
		mark();
		trdy_n = 1'b0;
		cyc(30);
		chk("busy", 8'h01, {7'h00, dl(5) != 8'h00});
		trdy_n = 1'b1;
		cyc(12);
		mark();
		cyc(30);
		chk("quiet", 8'h00, dl(5));
	endtask
	task automatic t_pins();
		wr(OFF_DEV_ENABLES + 8'h02, 8'h80);
		wr(OFF_DEV_ENABLES + 8'h03, 8'h9c);
		wr(OFF_FLOPPY_PAR, 8'h07);
		wr(OFF_SER_PAR_EN, 8'h02);
		wr(OFF_SER_PAR_EN + 8'h01, 8'h38);
		wr(OFF_MEM_GROUP_A, 8'h71);
		wr(OFF_MEM_GROUP_A + 8'h02, 8'h34);
		wr(OFF_MEM_GROUP_A + 8'h03, 8'h12);
		wr(OFF_IO_GROUP_C, 8'h31);
		wr(OFF_IO_GROUP_C + 8'h01, 8'h12);
		wr(OFF_RING_COUNT, 8'h03);
		wr(OFF_STANDBY_SEL, 8'hff);
		wr(OFF_STANDBY_SEL + 8'h01, 8'h0b);
		wr(OFF_SYS_STATE, 8'h01);
		mark();
		vcs_n = 1'b0;
		cyc(4);
		vcs_n = 1'b1;
		wake_chk("video cs", 8'h01);
		rd_chk("wake cause", OFF_RESET_CAUSE, 8'h04);
		drq = 8'h01;
		cyc(4);
		drq = 8'h00;
		wake_chk("parallel ch0", 8'h00);
		drq = 8'h08;
		cyc(4);
		drq = 8'h00;
		wake_chk("parallel ch3", 8'h01);
		drq = 8'h04;
		cyc(4);
		drq = 8'h00;
		wake_chk("floppy drq", 8'h01);
		bus.bus_cycle(0, 1'b1, 32'h0000_03f2);
		wake_chk("floppy old range", 8'h00);
		bus.bus_cycle(0, 1'b1, 32'h0000_0372);
		wake_chk("floppy new range", 8'h01);
		bus.bus_cycle(0, 1'b1, 32'h0000_03fb);
		wake_chk("com off", 8'h00);
		bus.bus_cycle(0, 1'b1, 32'h0000_02fb);
		wake_chk("com on", 8'h01);
		bus.bus_cycle(0, 1'b1, 32'h0000_0175);
		wake_chk("secondary disk", 8'h01);
		bus.bus_cycle(0, 1'b0, 32'h1235_c000);
		wake_chk("mem group hit", 8'h01);
		bus.bus_cycle(0, 1'b0, 32'h1236_0000);
		wake_chk("mem group miss", 8'h00);
		bus.bus_cycle(0, 1'b1, 32'h0000_1236);
		wake_chk("io group hit", 8'h01);
		bus.bus_cycle(0, 1'b1, 32'h0000_1238);
		wake_chk("io group miss", 8'h00);
		bus.bus_cycle(0, 1'b1, 32'h0000_0066);
		wake_chk("io group 066", 8'h01);
		kbd = 1'b1;
		cyc(4);
		kbd = 1'b0;
		wake_chk("keyboard irq", 8'h01);
		mouse = 1'b1;
		cyc(4);
		mouse = 1'b0;
		wake_chk("mouse irq", 8'h01);
		ide_pri = 1'b1;
		cyc(1);
		ide_pri = 1'b0;
		wake_chk("internal disk", 8'h01);
		usb_att = 1'b1;
		cyc(1);
		usb_att = 1'b0;
		wake_chk("usb attach", 8'h01);
		usb_bsy = 1'b1;
		cyc(2);
		usb_bsy = 1'b0;
		wake_chk("usb busy", 8'h01);
		for (int i = 0; i < 2; i++)
		begin
			ring = 1'b1;
			cyc(3);
			ring = 1'b0;
			cyc(3);
		end
		wake_chk("ring two", 8'h00);
		ring = 1'b1;
		cyc(3);
		ring = 1'b0;
		wake_chk("ring three", 8'h01);
		wr(OFF_SYS_STATE, 8'h00);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		#20000;
		errors++;
		wrap_up();
	end
	initial
	begin
		reset_n = 1'b0;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 8'h00;
		cfg_wdata = 8'h00;
		trdy_n = 1'b1;
		ide_pri = 1'b0;
		usb_att = 1'b0;
		usb_bsy = 1'b0;
		kbd = 1'b0;
		mouse = 1'b0;
		vcs_n = 1'b1;
		ring = 1'b0;
		drq = 8'h00;
		errors = 0;
		tests_run = 0;
		cyc(20);
		reset_n = 1'b1;
		t_reset();
		t_standby();
		t_mask();
		t_display();
		t_apm();
		t_busact();
		t_pins();
		wrap_up();
	end
endmodule // lpm_monitor_tb
